// file: logic/pg_monitor_pkg.sv
// Constants, register map and state encoding of the power-good monitor
package pg_monitor_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h15;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h16;
    localparam logic [7:0] ADDR_FAULT_LATCH = 8'h17;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ONE = 8'h19;
    localparam logic [7:0] ADDR_IRQ_TWO = 8'h1A;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_POLARITY = 7;
    localparam int BIT_OPEN_DRAIN = 6;
    localparam int BIT_WINDOW = 4;
    localparam int BIT_RAIL1_EN = 1;
    localparam int BIT_RAIL0_EN = 0;
    localparam int BIT_THERMAL_GATE = 2;
    localparam int BIT_LATCHED_SRC = 1;
    localparam int BIT_OPERATING = 0;
    localparam int BIT_SOFTWARE_RESET_CMD = 0;
    localparam int BIT_PG_DROP = 7;
    localparam int BIT_RESET_SEEN = 0;

    // ----------------------------------------
    // Writable masks and reset values
    // ----------------------------------------
    localparam logic [7:0] MASK_CTRL_ONE = 8'hD3;
    localparam logic [7:0] MASK_CTRL_TWO = 8'h07;
    localparam logic [7:0] MASK_FAULT = 8'h03;
    localparam logic [7:0] RESET_CTRL = 8'h00;
    localparam logic [1:0] RESET_FAULT = 2'h0;

    localparam int RAIL_COUNT = 2;

    // ----------------------------------------
    // Soft reset sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_CLEAR = 2'b01,
        ST_LOAD = 2'b10
    } reset_state_t;

endpackage

// file: logic/fault_latch_if.sv
// Connection between the register bank and the per-rail fault latches
`timescale 1ns/1ps
interface fault_latch_if;
    logic [pg_monitor_pkg::RAIL_COUNT-1:0] rail_valid;
    logic [pg_monitor_pkg::RAIL_COUNT-1:0] monitor_en;
    logic [pg_monitor_pkg::RAIL_COUNT-1:0] clear_req;
    logic soft_clear;
    logic [pg_monitor_pkg::RAIL_COUNT-1:0] fault_latch;

    modport bank (
        output rail_valid,
        output monitor_en,
        output clear_req,
        output soft_clear,
        input fault_latch
    );
    modport latch (
        input rail_valid,
        input monitor_en,
        input clear_req,
        input soft_clear,
        output fault_latch
    );
endinterface

// file: logic/rail_fault_latch.sv
// Per-rail sticky fault latches with write-one-to-clear
`timescale 1ns/1ps
module rail_fault_latch (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Bank side
    fault_latch_if.latch lat
);
    logic [pg_monitor_pkg::RAIL_COUNT-1:0] latch_q;
    logic [pg_monitor_pkg::RAIL_COUNT-1:0] next_latch;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Set beats write-one clear, soft clear beats set: a rail that fails in a write-one clearing cycle stays recorded
    genvar g;
    generate
        for (g = 0; g < pg_monitor_pkg::RAIL_COUNT; g++) begin : g_rail
            always_comb begin
                if (lat.soft_clear) begin
                    next_latch[g] = 1'b0;
                end else if (lat.monitor_en[g] && !lat.rail_valid[g]) begin
                    next_latch[g] = 1'b1;
                end else if (lat.clear_req[g] && lat.rail_valid[g]) begin
                    next_latch[g] = 1'b0;
                end else begin
                    next_latch[g] = latch_q[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= pg_monitor_pkg::RESET_FAULT;
        end else begin
            latch_q <= next_latch;
        end
    end

    assign lat.fault_latch = latch_q;
endmodule

// file: logic/power_good_monitor.sv
// Power-good register bank, output logic and software reset sequencer
`timescale 1ns/1ps
module power_good_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    // Configuration memory
    input wire logic [7:0] otp_ctrl_one,
    input wire logic [7:0] otp_ctrl_two,
    output logic otp_read_req,
    output logic serial_if_reset,
    // Analog monitors (asynchronous)
    input wire logic [1:0] rail_undervolt,
    input wire logic [1:0] rail_overvolt,
    input wire logic thermal_warn,
    input wire logic regulators_on,
    // Power-good pin
    output logic power_good_out,
    output logic power_good_oe,
    output logic analog_supply_drive
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic [1:0] uv_s;
    logic [1:0] ov_s;
    logic warn_s;
    logic on_s;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {regulators_on, thermal_warn, rail_overvolt, rail_undervolt};
            sync_b <= sync_a;
        end
    end

    assign uv_s = sync_b[1:0];
    assign ov_s = sync_b[3:2];
    assign warn_s = sync_b[4];
    assign on_s = sync_b[5];

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic pg_drop_irq;
    logic reset_seen;
    logic pg_valid_q;
    logic [7:0] rd_q;
    pg_monitor_pkg::reset_state_t state;
    logic [7:0] next_ctrl_one;
    logic [7:0] next_ctrl_two;
    logic next_pg_drop_irq;
    logic next_reset_seen;
    logic next_pg_valid_q;
    logic [7:0] next_rd_q;
    pg_monitor_pkg::reset_state_t next_state;

    fault_latch_if lat_if ();

    rail_fault_latch u_latch (
        .clock(clock),
        .rst_b(rst_b),
        .lat(lat_if.latch)
    );

    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] target);
        wr_hit = en && (a == target);
    endfunction

    // ----------------------------------------
    // Power-good combination
    // ----------------------------------------
    logic [1:0] rail_valid;
    logic [1:0] rail_en;
    logic live_ok;
    logic src_ok;
    logic pg_valid;

    always_comb begin
        rail_en = {ctrl_one[pg_monitor_pkg::BIT_RAIL1_EN], ctrl_one[pg_monitor_pkg::BIT_RAIL0_EN]};
        // Window mode also rejects overvoltage
        rail_valid = ~uv_s & ~(ov_s & {2{ctrl_one[pg_monitor_pkg::BIT_WINDOW]}});
        live_ok = &(rail_valid | ~rail_en);
        if (ctrl_two[pg_monitor_pkg::BIT_LATCHED_SRC]) begin
            src_ok = ~|lat_if.fault_latch;
        end else begin
            src_ok = live_ok;
        end
        pg_valid = src_ok;
        if (ctrl_two[pg_monitor_pkg::BIT_THERMAL_GATE] && warn_s) begin
            pg_valid = 1'b0;
        end
        // Gated operation only reports good while the regulators run
        if (!ctrl_two[pg_monitor_pkg::BIT_OPERATING] && !on_s) begin
            pg_valid = 1'b0;
        end
        if (state != pg_monitor_pkg::ST_RUN) begin
            pg_valid = 1'b0;
        end
    end

    assign lat_if.rail_valid = rail_valid;
    assign lat_if.monitor_en = rail_en;
    assign lat_if.clear_req = wr_hit(reg_wr_en, reg_addr, pg_monitor_pkg::ADDR_FAULT_LATCH)
        ? reg_wr_data[1:0] & pg_monitor_pkg::MASK_FAULT[1:0] : 2'h0;
    assign lat_if.soft_clear = (state == pg_monitor_pkg::ST_CLEAR);

    // ----------------------------------------
    // Register bank and reset sequencer
    // ----------------------------------------
    always_comb begin
        next_ctrl_one = ctrl_one;
        next_ctrl_two = ctrl_two;
        next_pg_drop_irq = pg_drop_irq;
        next_reset_seen = reset_seen;
        next_state = state;
        next_pg_valid_q = pg_valid;
        next_rd_q = rd_q;
        case (state)
            pg_monitor_pkg::ST_RUN: begin
                if (wr_hit(reg_wr_en, reg_addr, pg_monitor_pkg::ADDR_CTRL_ONE)) begin
                    next_ctrl_one = reg_wr_data & pg_monitor_pkg::MASK_CTRL_ONE;
                end
                if (wr_hit(reg_wr_en, reg_addr, pg_monitor_pkg::ADDR_CTRL_TWO)) begin
                    next_ctrl_two = reg_wr_data & pg_monitor_pkg::MASK_CTRL_TWO;
                end
                if (wr_hit(reg_wr_en, reg_addr, pg_monitor_pkg::ADDR_IRQ_ONE)
                    && reg_wr_data[pg_monitor_pkg::BIT_PG_DROP]) begin
                    next_pg_drop_irq = 1'b0;
                end
                if (wr_hit(reg_wr_en, reg_addr, pg_monitor_pkg::ADDR_IRQ_TWO)
                    && reg_wr_data[pg_monitor_pkg::BIT_RESET_SEEN]) begin
                    next_reset_seen = 1'b0;
                end
                // Set wins over a same-cycle clear
                if (pg_valid_q && !pg_valid) begin
                    next_pg_drop_irq = 1'b1;
                end
                if (wr_hit(reg_wr_en, reg_addr, pg_monitor_pkg::ADDR_SOFT_RESET)
                    && reg_wr_data[pg_monitor_pkg::BIT_SOFTWARE_RESET_CMD]) begin
                    next_state = pg_monitor_pkg::ST_CLEAR;
                end
            end
            pg_monitor_pkg::ST_CLEAR: begin
                next_ctrl_one = pg_monitor_pkg::RESET_CTRL;
                next_ctrl_two = pg_monitor_pkg::RESET_CTRL;
                next_pg_drop_irq = 1'b0;
                next_state = pg_monitor_pkg::ST_LOAD;
            end
            pg_monitor_pkg::ST_LOAD: begin
                next_ctrl_one = otp_ctrl_one & pg_monitor_pkg::MASK_CTRL_ONE;
                next_ctrl_two = otp_ctrl_two & pg_monitor_pkg::MASK_CTRL_TWO;
                next_reset_seen = 1'b1;
                next_state = pg_monitor_pkg::ST_RUN;
            end
            default: begin
                next_state = pg_monitor_pkg::ST_RUN;
            end
        endcase
        // Read data is registered, so it lands one cycle after the strobe
        if (reg_rd_en) begin
            case (reg_addr)
                pg_monitor_pkg::ADDR_CTRL_ONE: next_rd_q = ctrl_one;
                pg_monitor_pkg::ADDR_CTRL_TWO: next_rd_q = ctrl_two;
                pg_monitor_pkg::ADDR_FAULT_LATCH: next_rd_q = {6'h00, lat_if.fault_latch};
                pg_monitor_pkg::ADDR_SOFT_RESET: next_rd_q = {7'h00, state != pg_monitor_pkg::ST_RUN};
                pg_monitor_pkg::ADDR_IRQ_ONE: next_rd_q = {pg_drop_irq, 7'h00};
                pg_monitor_pkg::ADDR_IRQ_TWO: next_rd_q = {7'h00, reset_seen};
                default: next_rd_q = 8'h00;
            endcase
        end
    end

    // Power-on starts in the load state so the memory image is applied after release
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_one <= pg_monitor_pkg::RESET_CTRL;
            ctrl_two <= pg_monitor_pkg::RESET_CTRL;
            pg_drop_irq <= 1'b0;
            reset_seen <= 1'b0;
            pg_valid_q <= 1'b0;
            rd_q <= 8'h00;
            state <= pg_monitor_pkg::ST_LOAD;
        end else begin
            ctrl_one <= next_ctrl_one;
            ctrl_two <= next_ctrl_two;
            pg_drop_irq <= next_pg_drop_irq;
            reset_seen <= next_reset_seen;
            pg_valid_q <= next_pg_valid_q;
            rd_q <= next_rd_q;
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    logic pin_level;
    logic pin_oe;
    logic next_pin_level;
    logic next_pin_oe;

    always_comb begin
        next_pin_level = pg_valid_q ^ ctrl_one[pg_monitor_pkg::BIT_POLARITY];
        if (ctrl_one[pg_monitor_pkg::BIT_OPEN_DRAIN]) begin
            next_pin_oe = !next_pin_level;
            next_pin_level = 1'b0;
        end else begin
            next_pin_oe = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_level <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_level <= next_pin_level;
            pin_oe <= next_pin_oe;
        end
    end

    assign power_good_out = pin_level;
    assign power_good_oe = pin_oe;
    assign analog_supply_drive = !ctrl_one[pg_monitor_pkg::BIT_OPEN_DRAIN];
    assign reg_rd_data = rd_q;
    assign otp_read_req = (state == pg_monitor_pkg::ST_LOAD);
    assign serial_if_reset = (state == pg_monitor_pkg::ST_CLEAR);
endmodule

// file: tb/power_good_monitor_sva.sv
// Checker of register and soft reset behaviour of the power-good monitor
`timescale 1ns/1ps
module power_good_monitor_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    // Sequencer and pin stage
    input wire logic [7:0] otp_ctrl_one,
    input wire logic otp_read_req,
    input wire logic serial_if_reset,
    input wire logic analog_supply_drive
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Both sequencer outputs low means the bank takes writes
    logic run;
    assign run = !serial_if_reset && !otp_read_req;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_sw_seq;
        reg_wr_en && reg_addr == 8'h18 && reg_wr_data[0] && run
            |=> serial_if_reset && !otp_read_req ##1 otp_read_req ##1 run;
    endproperty
    a_sw_seq: assert property (p_sw_seq) else $error("soft reset sequence");
    property p_sw_clear;
        reg_rd_en && reg_addr == 8'h18 && run |=> reg_rd_data == 8'h00;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("reset bit stuck");
    property p_reload;
        otp_read_req ##1 !reg_wr_en [*3] ##0 (reg_rd_en && reg_addr == 8'h15)
            |=> reg_rd_data == ($past(otp_ctrl_one, 4) & 8'hD3);
    endproperty
    a_reload: assert property (p_reload) else $error("control not reloaded");
    property p_reset_seen;
        otp_read_req ##1 (reg_rd_en && reg_addr == 8'h1A) |=> reg_rd_data[0];
    endproperty
    a_reset_seen: assert property (p_reset_seen) else $error("reset status clear");
    property p_unmapped;
        reg_rd_en && (reg_addr < 8'h15 || reg_addr > 8'h1A) |=> reg_rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_rsv_one;
        reg_rd_en && reg_addr == 8'h15 |=> (reg_rd_data & 8'h2C) == 8'h00;
    endproperty
    a_rsv_one: assert property (p_rsv_one) else $error("reserved bits set");
    property p_rsv_fault;
        reg_rd_en && reg_addr == 8'h17 |=> reg_rd_data[7:2] == 6'h00;
    endproperty
    a_rsv_fault: assert property (p_rsv_fault) else $error("reserved latch bits");
    property p_drive_sel;
        reg_wr_en && reg_addr == 8'h15 && run |=> analog_supply_drive == !$past(reg_wr_data[6]);
    endproperty
    a_drive_sel: assert property (p_drive_sel) else $error("drive stage select");
    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_sw: cover property (reg_wr_en && reg_addr == 8'h18 && reg_wr_data[0] && run);
    c_unmapped: cover property (reg_rd_en && reg_addr > 8'h1A);
    c_open_drain: cover property (reg_wr_en && reg_addr == 8'h15 && reg_wr_data[6]);
endmodule

bind power_good_monitor power_good_monitor_sva chk (.clock, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wr_data, .reg_rd_data, .otp_ctrl_one, .otp_read_req, .serial_if_reset, .analog_supply_drive);

// file: tb/pg_pin_model.sv
// Board model of the power-good pin with its pull-up
`timescale 1ns/1ps
module pg_pin_model (
    // Pin drive from the device
    input wire logic power_good_out,
    input wire logic power_good_oe,
    // Level seen by system logic
    output logic pin_level
);
    // A released open-drain pin floats up to the pull-up level
    assign pin_level = power_good_oe ? power_good_out : 1'b1;
endmodule

// file: tb/tb_power_good_monitor.sv
// Self-checking testbench of the power-good monitor
`timescale 1ns/1ps
module tb_power_good_monitor;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] otp_ctrl_one = 8'h5B;
    logic [7:0] otp_ctrl_two = 8'hFD;
    logic [1:0] rail_undervolt = 2'h0;
    logic [1:0] rail_overvolt = 2'h0;
    logic thermal_warn = 1'b0;
    logic regulators_on = 1'b1;
    logic [7:0] reg_rd_data, d, c1, c2;
    logic otp_read_req, serial_if_reset, power_good_out, power_good_oe, analog_supply_drive, pin_level;
    logic [31:0] seed = 32'h0000002A;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #2.5 clock = ~clock;

    power_good_monitor dut (.clock, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .otp_ctrl_one, .otp_ctrl_two, .otp_read_req, .serial_if_reset, .rail_undervolt, .rail_overvolt,
        .thermal_warn, .regulators_on, .power_good_out, .power_good_oe, .analog_supply_drive);
    pg_pin_model pin (.power_good_out, .power_good_oe, .pin_level);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected {output enable, pin level}
    function automatic logic [1:0] exp_pin(input logic [7:0] a, b, input logic [1:0] lat);
        logic [1:0] v;
        logic g;
        v = ~rail_undervolt & ~(rail_overvolt & {2{a[4]}});
        g = b[1] ? (lat == 2'h0) : &(v | ~a[1:0]);
        g = g & !(b[2] & thermal_warn) & (b[0] | regulators_on);
        g = g ^ a[7];
        return {~a[6] | ~g, g};
    endfunction
    task chk(input string n, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, v);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = v;
        @(negedge clock);
        reg_wr_en = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd_en = 1'b0;
        d = reg_rd_data;
    endtask
    // Monitors pass two sync stages and two registers, or three via the fault latch; eight cycles leave margin
    task pin_chk(input logic [7:0] a, b, input logic [1:0] lat);
        logic [1:0] e;
        repeat (8) @(negedge clock);
        e = exp_pin(a, b, lat);
        chk("pin", {7'h00, e[0]}, {7'h00, pin_level});
        chk("oe", {7'h00, e[1]}, {7'h00, power_good_oe});
    endtask
    task finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        rd(8'h1A);
        chk("reset_seen", 8'h01, d & 8'h01);
        rd(8'h15);
        chk("ctrl_one", 8'h5B & 8'hD3, d);
        rd(8'h17);
        chk("fault", 8'h00, d);
        rd(8'h30);
        chk("unmapped", 8'h00, d);
        // Random configurations against live rail status
        for (int i = 0; i < 40; i++) begin
            c1 = 8'(xs());
            c2 = 8'(xs()) & 8'hFD;
            {thermal_warn, regulators_on, rail_overvolt, rail_undervolt} = 6'(xs());
            wr(8'h15, c1);
            wr(8'h16, c2);
            rd(8'h15);
            chk("ctrl_one", c1 & 8'hD3, d);
            rd(8'h16);
            chk("ctrl_two", c2 & 8'h07, d);
            pin_chk(c1, c2, 2'h0);
        end
        // Latched source: set, refused early clear, clear once valid
        {thermal_warn, regulators_on, rail_overvolt, rail_undervolt} = 6'h10;
        wr(8'h15, 8'h03);
        wr(8'h16, 8'h03);
        for (int r = 0; r < 2; r++) begin
            wr(8'h17, 8'h03);
            wr(8'h19, 8'h80);
            pin_chk(8'h03, 8'h03, 2'h0);
            rail_undervolt[r] = 1'b1;
            pin_chk(8'h03, 8'h03, 2'h1 << r);
            rd(8'h17);
            chk("fault", 8'h01 << r, d);
            rd(8'h19);
            chk("pg_drop", 8'h80, d & 8'h80);
            wr(8'h17, 8'h03);
            rd(8'h17);
            chk("fault_early", 8'h01 << r, d);
            rail_undervolt[r] = 1'b0;
            pin_chk(8'h03, 8'h03, 2'h1 << r);
            wr(8'h17, 8'h03);
            pin_chk(8'h03, 8'h03, 2'h0);
            rd(8'h17);
            chk("fault", 8'h00, d);
            wr(8'h19, 8'h80);
            rd(8'h19);
            chk("pg_drop", 8'h00, d & 8'h80);
        end
        // Soft reset with a write inside the sequence, which must be dropped
        wr(8'h1A, 8'h01);
        rd(8'h1A);
        chk("reset_seen", 8'h00, d & 8'h01);
        wr(8'h18, 8'hFF);
        wr(8'h15, 8'h00);
        rd(8'h15);
        chk("ctrl_one", 8'h5B & 8'hD3, d);
        rd(8'h16);
        chk("ctrl_two", 8'hFD & 8'h07, d);
        rd(8'h18);
        chk("software_reset_cmd", 8'h00, d);
        rd(8'h1A);
        chk("reset_seen", 8'h01, d & 8'h01);
        rd(8'h17);
        chk("fault", 8'h00, d);
        finish_test();
    end
endmodule
